// ### core/tsi_switch_core.sv
// time-slot switch core: input offset alignment and connection word decoding
module tsi_switch_core (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic framePulseIn,
    input wire logic [15:0] rxData,
    output logic [15:0] txData,
    output logic [15:0] txOe,
    output logic controlChannelOut,
    input wire logic [7:0] addr,
    input wire logic [15:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [15:0] rdData
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic fpMeta;
        logic fpSync;
        logic fpPrev;
        logic [15:0] rxMeta;
        logic [15:0] rxSync;
        logic [15:0] rxPrev;
        logic [7:0] pos;
        logic bank;
        logic [63:0] ofsAll;
        logic [7:0] mode;
        logic [63:0][15:0] cm;
        logic [1:0][63:0][7:0] dm;
        logic [15:0][7:0] shifter;
        logic [15:0] txData;
        logic [15:0] txOe;
        logic control_channel_out;
        logic [15:0] rdData;
        logic [4:0] measCnt;
        logic measArm;
        logic [2:0] measOfs;
        logic measFlag;
        logic overflow;
    } tsi_core_state_type;

    tsi_core_state_type state;
    tsi_core_state_type next_state;

    logic fifoInValid;
    logic fifoInReady;
    logic [tsi_pkg::FIFO_W-1:0] fifoInData;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [tsi_pkg::FIFO_W-1:0] fifoOutData;
    logic frameEdge;
    logic cmAccess;
    logic altMode;

    assign txData = state.txData;
    assign txOe = state.txOe;
    assign controlChannelOut = state.control_channel_out;
    assign rdData = state.rdData;

    // connection writes queue here; the drain stalls while channel bytes are fetched
    assign cmAccess = (addr[7:6] == tsi_pkg::CM_PAGE);
    assign fifoInValid = wrStrobe && cmAccess;
    assign fifoInData = {addr[tsi_pkg::IDX_W-1:0], wrData};
    assign fifoOutReady = (state.pos[2:0] != 3'h0);
    assign frameEdge = state.fpSync && !state.fpPrev;
    assign altMode = state.mode[tsi_pkg::MODE_ALT];

    tsi_fifo #(
        .WIDTH(tsi_pkg::FIFO_W),
        .DEPTH(tsi_pkg::FIFO_DEPTH)
    ) cmWriteQueue (
        .clock(clock),
        .reset_n(reset_n),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // all next-state logic of the core
    always_comb begin
        logic [7:0] rel;
        logic [1:0] chR;
        logic bitIn;
        logic [15:0] w;
        logic [6:0] srcC;
        logic [5:0] srcI;
        logic rdBank;
        logic [7:0] outByte;
        logic [3:0] mStr;
        logic [4:0] half;
        rel = 8'h00;
        chR = 2'h0;
        bitIn = 1'b0;
        w = 16'h0000;
        srcC = 7'h00;
        srcI = 6'h00;
        rdBank = 1'b0;
        outByte = 8'h00;
        mStr = state.mode[tsi_pkg::MODE_MSTR_LSB +: 4];
        half = 5'h00;
        next_state = state;

        // pins pass two flops; a third copy feeds edge detection only
        next_state.fpMeta = framePulseIn;
        next_state.fpSync = state.fpMeta;
        next_state.fpPrev = state.fpSync;
        next_state.rxMeta = rxData;
        next_state.rxSync = state.rxMeta;
        next_state.rxPrev = state.rxSync;

        // frame position restarts on each frame pulse
        // frame reference point
        if (frameEdge) begin
            next_state.pos = 8'h00;
            next_state.bank = !state.bank;
        end else begin
            next_state.pos = state.pos + 8'h01;
        end

        // receive: each stream samples at its own delay after the frame edge
        for (int n = 0; n < tsi_pkg::NUM_STR; n++) begin
            // inverted edge meaning in alternate mode
            rel = state.pos - tsi_pkg::delayOf(state.ofsAll[4 * n +: 4], altMode);
            chR = rel[7:6];
            // loopback takes the stream's own output bit
            bitIn = state.cm[{4'(n), chR}][tsi_pkg::CM_CHANNEL_LOOPBACK] ? state.txData[n]
                                                               : state.rxSync[n];
            if (rel[2:0] == 3'(tsi_pkg::SAMPLE_PT)) begin
                next_state.shifter[n] = {state.shifter[n][6:0], bitIn};
                if (rel[5:3] == 3'h7) begin
                    next_state.dm[state.bank][{4'(n), chR}] = {state.shifter[n][6:0], bitIn};
                end
            end
        end

        // transmit: a new bit per stream at each bit cell start, msb first
        if (state.pos[2:0] == 3'h0) begin
            for (int n = 0; n < tsi_pkg::NUM_STR; n++) begin
                w = state.cm[{4'(n), state.pos[7:6]}];
                // rate limits the source channel width
                srcC = w[tsi_pkg::CM_CH_LSB +: 7] & tsi_pkg::chanMask(state.mode[2:1]);
                srcI = {w[tsi_pkg::CM_STR_LSB +: 4], srcC[tsi_pkg::CH_W-1:0]};
                // constant delay always reads last frame's bank
                rdBank = (w[tsi_pkg::CM_CONST] || srcC >= {5'h00, state.pos[7:6]})
                         ? !state.bank : state.bank;
                // processor channel sends the word's low byte
                outByte = w[tsi_pkg::CM_PC] ? w[7:0] : state.dm[rdBank][srcI];
                next_state.txData[n] = outByte[3'h7 - state.pos[5:3]];
                next_state.txOe[n] = w[tsi_pkg::CM_OE];
            end
        end

        // next channel's control bits, stream 0 first, four clocks per stream
        if (state.pos[1:0] == 2'h0) begin
            next_state.control_channel_out = state.cm[{state.pos[5:2], state.pos[7:6] + 2'h1}][tsi_pkg::CM_CCO];
        end

        // measurement: clocks from frame edge to first transition on the chosen stream
        if (frameEdge) begin
            next_state.measArm = 1'b1;
            next_state.measCnt = 5'h00;
        end else if (state.measArm) begin
            if (state.rxSync[mStr] != state.rxPrev[mStr] || state.measCnt == tsi_pkg::MEAS_MAX) begin
                half = 5'(32'(state.measCnt) / tsi_pkg::HALF_CYC);
                // offset bits plus inverted half flag
                next_state.measOfs = half[3:1];
                next_state.measFlag = !half[0];
                next_state.measArm = 1'b0;
            end else begin
                next_state.measCnt = state.measCnt + 5'h01;
            end
        end

        // queued connection writes land between fetch cycles
        if (fifoOutValid && fifoOutReady) begin
            next_state.cm[fifoOutData[tsi_pkg::FIFO_W-1:16]] = fifoOutData[15:0];
        end

        // register writes; a full queue drops the write and flags it
        if (wrStrobe) begin
            // four nibbles per offset register, stream 12 at the low end of the last
            if (addr >= tsi_pkg::ADDR_OFS0 && addr <= tsi_pkg::ADDR_OFS3) begin
                next_state.ofsAll[16 * addr[1:0] +: 16] = wrData;
            end else if (addr == tsi_pkg::ADDR_MODE) begin
                next_state.mode = wrData[7:0];
            end
        end

        // read data stands for one cycle only, unmapped reads give zero
        next_state.rdData = 16'h0000;
        if (rdStrobe) begin
            if (addr >= tsi_pkg::ADDR_OFS0 && addr <= tsi_pkg::ADDR_OFS3) begin
                next_state.rdData = state.ofsAll[16 * addr[1:0] +: 16];
            end else if (addr == tsi_pkg::ADDR_MODE) begin
                next_state.rdData = {8'h00, state.mode};
            end else if (addr == tsi_pkg::ADDR_MEAS) begin
                next_state.rdData[2:0] = state.measOfs;
                next_state.rdData[tsi_pkg::MEAS_FLAG] = state.measFlag;
                next_state.rdData[tsi_pkg::MEAS_BUSY] = state.measArm;
            end else if (addr == tsi_pkg::ADDR_STAT) begin
                next_state.rdData[tsi_pkg::STAT_OVF] = state.overflow;
                next_state.rdData[tsi_pkg::STAT_EMPTY] = !fifoOutValid;
                next_state.overflow = 1'b0;
            end else if (cmAccess) begin
                next_state.rdData = state.cm[addr[tsi_pkg::IDX_W-1:0]];
            end
        end

        // overflow set wins over the clear by a status read
        if (fifoInValid && !fifoInReady) begin
            next_state.overflow = 1'b1;
        end
    end

    // single state register; storage resets too, so outputs are defined at once
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= '0;
            state.mode <= tsi_pkg::MODE_RESET;
            state.ofsAll <= {4{tsi_pkg::OFS_RESET}};
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers watched by the checks below
    logic [15:0] cmS0;
    logic [6:0] srcC0;
    logic [5:0] srcS0;
    logic [7:0] rel0;
    logic [7:0] relS3;
    assign cmS0 = state.cm[{4'h0, state.pos[7:6]}];
    assign srcC0 = cmS0[6:0] & tsi_pkg::chanMask(state.mode[2:1]);
    assign srcS0 = {cmS0[10:7], srcC0[1:0]};
    assign rel0 = state.pos - tsi_pkg::delayOf(state.ofsAll[3:0], altMode);
    // stream 3 is the looped stream of the bench, so its sample point is watched
    assign relS3 = state.pos - tsi_pkg::delayOf(state.ofsAll[15:12], altMode);

    AST_FRAME_RESTART: assert property (
        @(posedge clock) disable iff (!reset_n)
        frameEdge |=> (state.pos == 8'h00) ##1 (state.pos == 8'h01))
        else $error("frame position did not restart on frame pulse");

    AST_OUTPUT_ENABLE: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state.pos[2:0] == 3'h0) |=> (txOe[0] == $past(cmS0[tsi_pkg::CM_OE])))
        else $error("stream 0 output enable does not follow the connection word");

    AST_PROC_BYTE: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state.pos[2:0] == 3'h0 && cmS0[tsi_pkg::CM_PC])
        |=> (txData[0] == $past(cmS0[3'h7 - state.pos[5:3]])))
        else $error("processor channel did not send the low byte");

    AST_CONST_DELAY: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state.pos[2:0] == 3'h0 && !cmS0[tsi_pkg::CM_PC] && cmS0[tsi_pkg::CM_CONST])
        |=> (txData[0] == $past(state.dm[!state.bank][srcS0][3'h7 - state.pos[5:3]])))
        else $error("constant delay channel did not read the previous frame");

    AST_CONTROL_EARLY: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state.pos[1:0] == 2'h0)
        |=> (controlChannelOut == $past(state.cm[{state.pos[5:2], state.pos[7:6] + 2'h1}][12]))
            ##1 $stable(controlChannelOut))
        else $error("control channel bit is not the next channel's");

    AST_MEAS_RANGE: assert property (
        @(posedge clock) disable iff (!reset_n)
        $fell(state.measArm) |-> (state.measOfs <= 3'h4))
        else $error("measured offset beyond four periods");

    AST_OFS3_READBACK: assert property (
        @(posedge clock) disable iff (!reset_n)
        (rdStrobe && addr == tsi_pkg::ADDR_OFS3) |=> (rdData == $past(state.ofsAll[63:48])))
        else $error("offset register for streams 12 to 15 read back wrong");

    AST_LOOPBACK: assert property (
        @(posedge clock) disable iff (!reset_n)
        (relS3[2:0] == 3'(tsi_pkg::SAMPLE_PT) && state.cm[{4'h3, relS3[7:6]}][15])
        |=> (state.shifter[3][0] == $past(txData[3])))
        else $error("looped-back channel did not take the output bit");

    AST_RX_SAMPLE: assert property (
        @(posedge clock) disable iff (!reset_n)
        (rel0[2:0] == 3'(tsi_pkg::SAMPLE_PT) && !state.cm[{4'h0, rel0[7:6]}][15])
        |=> (state.shifter[0][0] == $past(state.rxSync[0])))
        else $error("stream 0 did not sample its input at the delayed point");

    AST_OFS_WRITE: assert property (
        @(posedge clock) disable iff (!reset_n)
        (wrStrobe && addr <= tsi_pkg::ADDR_OFS3)
        |=> (state.ofsAll[16 * $past(addr[1:0]) +: 16] == $past(wrData)))
        else $error("offset register write did not land");

    AST_TX_HOLD: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state.pos[2:0] != 3'h0) |=> ($stable(txData) && $stable(txOe)))
        else $error("serial outputs changed inside a bit cell");

    AST_VAR_DELAY: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state.pos[2:0] == 3'h0 && !cmS0[tsi_pkg::CM_PC] && !cmS0[tsi_pkg::CM_CONST]
         && srcC0 < {5'h00, state.pos[7:6]})
        |=> (txData[0] == $past(state.dm[state.bank][srcS0][3'h7 - state.pos[5:3]])))
        else $error("variable delay channel did not read the current frame");

    AST_RATE_MASK: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state.pos[2:0] == 3'h0 && !cmS0[tsi_pkg::CM_PC] && !cmS0[tsi_pkg::CM_CONST]
         && srcC0 >= {5'h00, state.pos[7:6]})
        |=> (txData[0] == $past(state.dm[!state.bank][srcS0][3'h7 - state.pos[5:3]])))
        else $error("masked source channel did not pick the previous frame");
endmodule

// ### core/tsi_pkg.sv
// shared constants, register map and helper functions of the switch core
package tsi_pkg;

    // switch geometry: 16 streams, a reduced number of channels held per stream
    localparam int NUM_STR = 16;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int IDX_W = 6;

    // clock and serial timing
    localparam int CLOCK_NS = 5;
    localparam int SER_PERIOD_NS = 20;
    localparam int HALF_CYC = (SER_PERIOD_NS / 2) / CLOCK_NS;
    localparam int BIT_CYC = 4 * HALF_CYC;
    localparam int SAMPLE_PT = 3 * HALF_CYC;
    localparam int FRAME_CYC = NUM_CH * 8 * BIT_CYC;
    localparam int MAX_HALF = 9;
    localparam logic [4:0] MEAS_MAX = 5'(MAX_HALF * HALF_CYC);

    // register addresses
    localparam logic [7:0] ADDR_OFS0 = 8'h00;
    localparam logic [7:0] ADDR_OFS3 = 8'h03;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_MEAS = 8'h05;
    localparam logic [7:0] ADDR_STAT = 8'h06;
    localparam logic [1:0] CM_PAGE = 2'h1;

    // reset values
    localparam logic [15:0] OFS_RESET = 16'h0000;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // connection word fields
    localparam int CM_CHANNEL_LOOPBACK = 15;
    localparam int CM_CONST = 14;
    localparam int CM_PC = 13;
    localparam int CM_CCO = 12;
    localparam int CM_OE = 11;
    localparam int CM_STR_LSB = 7;
    localparam int CM_CH_LSB = 0;

    // mode register fields
    localparam int MODE_ALT = 0;
    localparam int MODE_RATE_LSB = 1;
    localparam int MODE_MSTR_LSB = 4;

    // measurement and status register fields
    localparam int MEAS_FLAG = 11;
    localparam int MEAS_BUSY = 15;
    localparam int STAT_OVF = 0;
    localparam int STAT_EMPTY = 1;

    // connection write fifo
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_W = IDX_W + 16;

    // stream rate codes
    localparam logic [1:0] RATE_2M = 2'h0;
    localparam logic [1:0] RATE_4M = 2'h1;

    // receive delay in system clocks from stream nibble {offset[2:0], edge}
    function automatic logic [7:0] delayOf(input logic [3:0] nib, input logic alt);
        logic [4:0] h;
        h = {1'b0, nib[3:1], 1'b0} + {4'h0, nib[0] ^ alt};
        return 8'(32'(h) * HALF_CYC);
    endfunction

    // usable source channel bits for the stream rate
    function automatic logic [6:0] chanMask(input logic [1:0] rate);
        case (rate)
            RATE_2M: return 7'h1F;
            RATE_4M: return 7'h3F;
            default: return 7'h7F;
        endcase
    endfunction

endpackage

// ### core/tsi_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
module tsi_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW:0] count;
    } tsi_fifo_state_type;

    tsi_fifo_state_type state;
    tsi_fifo_state_type next_state;
    logic push;
    logic pop;

    // full and empty come straight from the occupancy count
    assign inReady = (state.count != (PW + 1)'(DEPTH));
    assign outValid = (state.count != '0);
    assign outData = state.mem[state.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // pointer and storage update
    always_comb begin
        next_state = state;
        if (push) begin
            next_state.mem[state.wrPtr] = inData;
            next_state.wrPtr = state.wrPtr + 1'b1;
        end
        if (pop) begin
            next_state.rdPtr = state.rdPtr + 1'b1;
        end
        next_state.count = state.count + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

// ### test/tsi_stream_model.sv
// far-side model: frame pulse, delayed serial input streams, capture of the outputs
module tsi_stream_model (
    input wire logic clock,
    input wire logic altMode,
    input wire logic [63:0] offsetCfg,
    input wire logic [15:0] txData,
    input wire logic [15:0] txOe,
    input wire logic controlChannelOut,
    output logic framePulseIn,
    output logic [15:0] rxData
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] cnt = 8'h00;
    logic [7:0] frm = 8'h00;
    logic [7:0] txByte [16][4];
    logic txOeSeen [16][4];
    logic ccoSeen [16][4];

    // stream 0 adds the frame count so that frame age shows at the outputs
    function automatic logic [7:0] rxByte(input int s, input int c, input logic [7:0] f);
        return 8'(32'h96 + 32'h3C * s + 32'h57 * c) + ((s == 0) ? f : 8'h00);
    endfunction

    initial begin
        framePulseIn = 1'b0;
        rxData = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // streams arrive late by the programmed offset; the sample point falls two clocks into each cell
    always @(posedge clock) begin
        logic [7:0] rel;
        logic [4:0] half;
        logic [7:0] b;
        cnt <= cnt + 8'h01;
        if (cnt == 8'hFF) begin
            frm <= frm + 8'h01;
        end
        framePulseIn <= (cnt < 8'h04);
        for (int s = 0; s < 16; s++) begin
            half = {1'b0, offsetCfg[4*s+1 +: 3], 1'b0} + {4'h0, offsetCfg[4*s] ^ altMode};
            rel = cnt - 8'h05 - {2'b00, half, 1'b0};
            b = rxByte(s, int'(rel[7:6]), frm);
            rxData[s] <= b[3'h7 - rel[5:3]];
        end
        // data and enable are read six clocks into each cell, two clocks before their next change
        if (cnt[2:0] == 3'h2) begin
            rel = cnt - 8'h0A;
            for (int s = 0; s < 16; s++) begin
                txByte[s][rel[7:6]][3'h7 - rel[5:3]] <= txData[s];
                txOeSeen[s][rel[7:6]] <= txOe[s];
            end
        end
        if (cnt[1:0] == 2'h0) begin
            rel = cnt - 8'h08;
            ccoSeen[rel[5:2]][rel[7:6] + 2'h1] <= controlChannelOut;
        end
    end
endmodule

// ### test/tsi_switch_core_tb_top.sv
// testbench of the switch core: registers, switching paths and input alignment
module tsi_switch_core_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [15:0] fLoop = 16'h0001 << tsi_pkg::CM_CHANNEL_LOOPBACK;
    localparam logic [15:0] fConst = 16'h0001 << tsi_pkg::CM_CONST;
    localparam logic [15:0] fPc = 16'h0001 << tsi_pkg::CM_PC;
    localparam logic [15:0] fCco = 16'h0001 << tsi_pkg::CM_CCO;
    localparam logic [15:0] fOe = 16'h0001 << tsi_pkg::CM_OE;

    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wrData = 16'h0000;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic [15:0] rdData;
    logic framePulseIn;
    logic [15:0] rxData;
    logic [15:0] txData;
    logic [15:0] txOe;
    logic controlChannelOut;
    logic altSel = 1'b0;
    logic [63:0] ofsCfg = 64'h0;
    int errCount = 0;
    int cmpCount = 0;

    always #2.5 clock = ~clock;

    tsi_switch_core u_dut (
        .clock(clock),
        .reset_n(reset_n),
        .framePulseIn(framePulseIn),
        .rxData(rxData),
        .txData(txData),
        .txOe(txOe),
        .controlChannelOut(controlChannelOut),
        .addr(addr),
        .wrData(wrData),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe),
        .rdData(rdData)
    );

    tsi_stream_model u_model (
        .clock(clock),
        .altMode(altSel),
        .offsetCfg(ofsCfg),
        .txData(txData),
        .txOe(txOe),
        .controlChannelOut(controlChannelOut),
        .framePulseIn(framePulseIn),
        .rxData(rxData)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [7:0] expByte(input int s, input int c);
        return 8'(32'h96 + 32'h3C * s + 32'h57 * c);
    endfunction

    function automatic logic [7:0] cmAddr(input int s, input int c);
        return {tsi_pkg::CM_PAGE, 4'(s), 2'(c)};
    endfunction

    function automatic logic [15:0] cw(input logic [15:0] fl, input int s, input int c);
        return fl | 16'(s << tsi_pkg::CM_STR_LSB) | 16'(c << tsi_pkg::CM_CH_LSB);
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // strobes stay up between back-to-back writes; idle lowers them
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        rdStrobe <= 1'b0;
        @(posedge clock);
    endtask

    task automatic idle(input int n);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b0;
        repeat (n) @(posedge clock);
    endtask

    // read data is looked at only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        addr <= a;
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        @(posedge clock);
        chk($sformatf("register %h", a), exp, rdData);
    endtask

    task automatic chkTx(input int s, input int c, input logic [7:0] exp);
        chk($sformatf("tx byte %0d.%0d", s, c), {8'h00, exp}, {8'h00, u_model.txByte[s][c]});
    endtask

    // captures are read late in the frame, when channels 0 to 2 are complete
    task automatic checkPaths(input logic late);
        wait (u_model.cnt == 8'hF0);
        chkTx(0, 0, expByte(12, 1));
        chkTx(0, 1, 8'hE1);
        chkTx(0, 2, u_model.txByte[7][2] + (late ? 8'h00 : 8'h01));
        for (int i = 0; i < 4; i++) begin
            chkTx(8 + i, 1, expByte(12 + i, 1));
        end
        chkTx(4, 2, 8'h5A);
        chkTx(2, 0, 8'hC3);
        chkTx(6, 2, u_model.txByte[7][2] + 8'h01);
        chk("enable off", 16'h0000, 16'(u_model.txOeSeen[5][2]));
        chk("enable on", 16'h0001, 16'(u_model.txOeSeen[4][2]));
        chk("control own", 16'h0001, 16'(u_model.ccoSeen[5][2]));
        chk("control next", 16'h0000, 16'(u_model.ccoSeen[5][1]));
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 5; i++) begin
            rd(8'(i), 16'h0000);
        end
        rd(tsi_pkg::ADDR_STAT, 16'h0001 << tsi_pkg::STAT_EMPTY);
        rd(8'h20, 16'h0000);
        wr(tsi_pkg::ADDR_OFS3, 16'hA5C3);
        rd(tsi_pkg::ADDR_OFS3, 16'hA5C3);
        $display("test registers done");
        // looped stream 3 keeps zero offset bits
        wr(tsi_pkg::ADDR_OFS3, 16'h9830);
        ofsCfg <= {16'h9830, 48'h0};
        for (int i = 0; i < 4; i++) begin
            wr(cmAddr(8 + i, 1), cw(fConst | fOe, 12 + i, 1));
        end
        wr(cmAddr(3, 1), fLoop | fPc | fOe | 16'h005A);
        wr(cmAddr(4, 2), cw(fConst | fOe, 3, 1));
        wr(cmAddr(2, 0), fPc | fOe | 16'h00C3);
        wr(cmAddr(6, 2), cw(fOe, 0, 0));
        wr(cmAddr(7, 2), cw(fConst | fOe, 0, 0));
        wr(cmAddr(5, 2), fCco);
        wr(cmAddr(0, 0), cw(fConst | fOe, 12, 1));
        wr(cmAddr(0, 1), fPc | fOe | 16'h00E1);
        // channel 32 folds to channel 0 at the slow rate only
        wr(cmAddr(0, 2), cw(fOe, 0, 32));
        idle(800);
        checkPaths(1'b0);
        $display("test primary mode done");
        // alternate mode flips the half step; stream 3 edge bit keeps its sample point
        wr(tsi_pkg::ADDR_OFS0, 16'h1000);
        ofsCfg[15:0] <= 16'h1000;
        wr(tsi_pkg::ADDR_MODE, 16'h0005);
        altSel <= 1'b1;
        rd(tsi_pkg::ADDR_MODE, 16'h0005);
        idle(800);
        checkPaths(1'b1);
        $display("test alternate mode done");
        repeat (400) begin
            wr(cmAddr(1, 3), fPc | fOe | 16'h0077);
        end
        rd(tsi_pkg::ADDR_STAT, 16'h0001 << tsi_pkg::STAT_OVF);
        rd(tsi_pkg::ADDR_STAT, 16'h0000);
        idle(100);
        rd(tsi_pkg::ADDR_STAT, 16'h0001 << tsi_pkg::STAT_EMPTY);
        rd(cmAddr(1, 3), fPc | fOe | 16'h0077);
        rd(cmAddr(4, 2), cw(fConst | fOe, 3, 1));
        $display("test queue overflow done");
        wrap_up();
    end

    // watchdog: the tests need about 2500 clocks
    initial begin
        repeat (20000) @(posedge clock);
        errCount++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule
